// file: pkg/trace_pkg.sv
/*
 trace_pkg: register offsets, field positions, reset values, trigger modes
 and bus carriers for the trace trigger and capture block.
 assumes an AXI4-Lite master with 32-bit data and a 16-bit cpu address bus.
*/
package trace_pkg;
   localparam logic [7:0] control_off = 8'h00;
   localparam logic [7:0] trigger_off = 8'h04;
   localparam logic [7:0] status_off = 8'h08;
   localparam logic [7:0] count_off = 8'h0c;
   localparam logic [7:0] fifo_high_off = 8'h10;
   localparam logic [7:0] fifo_low_off = 8'h14;
   localparam logic [7:0] match_a_off = 8'h18;
   localparam logic [7:0] match_b_off = 8'h1c;
   // control bits
   localparam int ctl_enable_pos = 7;
   localparam int ctl_arm_pos = 6;
   localparam int ctl_tag_pos = 5;
   localparam int ctl_brk_pos = 4;
   // trigger bits
   localparam int trg_qualify_pos = 7;
   localparam int trg_begin_pos = 6;
   localparam logic [7:0] control_reset = 8'h00;
   localparam logic [7:0] trigger_reset = 8'h00;
   localparam int fifo_depth = 8;
   localparam logic [1:0] okay = 2'b00;
   localparam logic [1:0] slverr = 2'b10;

   typedef enum logic [3:0] {
      mode_a_only = 4'h0,
      mode_a_or_b = 4'h1,
      mode_a_and_b = 4'h2,
      mode_a_and_not_b = 4'h3,
      mode_event_b = 4'h4,
      mode_a_then_event_b = 4'h5,
      mode_a_then_b = 4'h6,
      mode_inside = 4'h7,
      mode_outside = 4'h8
   } trig_mode_e;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic cof_dest;
      logic cof_branch;
      logic opcode_fetch;
   } cpu_bus_s;

   typedef struct packed {
      logic hit_a;
      logic hit_b;
      logic trigger;
      logic brk_source;
   } trig_out_s;
endpackage : trace_pkg

// file: rtl/trace_capture_fifo.sv
/*
 trace_capture_fifo: eight-entry shift fifo for captured words.
 assumes push and pop qualified by the controller; push while full drops oldest.
*/
`timescale 1ns/1ps
module trace_capture_fifo #(
   parameter int depth = 8,
   parameter int width = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic push,
   input wire logic [width-1:0] push_data,
   input wire logic pop,
   input wire logic clear,
   output logic [width-1:0] oldest,
   output logic full
);
   logic [width-1:0] mem_reg [depth];
   logic [$clog2(depth+1)-1:0] fill_reg;
   wire at_full = fill_reg == ($clog2(depth+1))'(depth);
   // a pop on an empty fifo is ignored so a push still lands
   wire take = pop && fill_reg != '0;

   // oldest entry sits in mem_reg[0]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fill_reg <= '0;
      end else if (clear) begin
         fill_reg <= '0;
      end else if (push && !take && !at_full) begin
         fill_reg <= fill_reg + 1'b1;
      end else if (take && !push) begin
         fill_reg <= fill_reg - 1'b1;
      end
   end

   genvar i;
   generate
      for (i = 0; i < depth; i = i + 1) begin : g_slot
         wire shift = take || (push && at_full);
         wire [$clog2(depth+1)-1:0] idx = ($clog2(depth+1))'(i);
         wire [$clog2(depth+1)-1:0] tgt = shift ? fill_reg - 1'b1 : fill_reg;
         logic [width-1:0] nxt;
         always_comb begin
            nxt = mem_reg[i];
            if (shift) nxt = (i < depth-1) ? mem_reg[(i+1) % depth] : '0;
            if (push && idx == tgt) nxt = push_data;
         end
         always_ff @(posedge clk or posedge rst) begin
            if (rst) mem_reg[i] <= '0;
            else mem_reg[i] <= nxt;
         end
      end
   endgenerate

   assign oldest = mem_reg[0];
   assign full = at_full;
endmodule : trace_capture_fifo

// file: rtl/trace_trigger_and_capture_fifo.sv
/*
 trace_trigger_and_capture_fifo: arm logic, trigger control, break request,
 capture fifo and AXI4-Lite register slave.
 assumes cpu bus inputs synchronous to clk; sys_reset is the mcu reset event,
 distinct from rst (power-on) which initialises everything.
*/
`timescale 1ns/1ps
module trace_trigger_and_capture_fifo (
   input wire logic clk,
   input wire logic rst,
   input wire logic sys_reset,
   input wire trace_pkg::cpu_bus_s cpu,
   output logic break_request,
   output logic break_is_tag,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [7:0] control_reg;
   logic [7:0] trigger_reg;
   logic [15:0] comp_a_reg;
   logic [15:0] comp_b_reg;
   logic armed_status_flag;
   logic comp_a_match_flag;
   logic comp_b_match_flag;
   logic comp_c_match_flag;
   logic a_seen_reg;
   logic triggered_reg;
   logic [3:0] valid_word_count;
   logic [15:0] prev_addr_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic brk_reg;

   wire module_enable_bit = control_reg[trace_pkg::ctl_enable_pos];
   wire arm_bit = control_reg[trace_pkg::ctl_arm_pos];
   wire tag_bit = control_reg[trace_pkg::ctl_tag_pos];
   wire break_request_enable = control_reg[trace_pkg::ctl_brk_pos];
   wire opcode_qualify_select = trigger_reg[trace_pkg::trg_qualify_pos];
   wire [3:0] mode = trigger_reg[3:0];
   wire event_mode = (mode == 4'(trace_pkg::mode_event_b)) ||
                     (mode == 4'(trace_pkg::mode_a_then_event_b));
   // event modes force a begin run
   wire begin_run = trigger_reg[trace_pkg::trg_begin_pos] || event_mode;
   wire armed = module_enable_bit && arm_bit;

   // axi write path: address and data taken in either order
   wire wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
   wire wr_control = wr_go && aw_addr_reg == trace_pkg::control_off && w_strb_reg[0];
   wire wr_trigger = wr_go && aw_addr_reg == trace_pkg::trigger_off && w_strb_reg[0];
   wire wr_comp_a = wr_go && aw_addr_reg == trace_pkg::match_a_off;
   wire wr_comp_b = wr_go && aw_addr_reg == trace_pkg::match_b_off;
   wire wr_known = wr_control || wr_trigger || wr_comp_a || wr_comp_b ||
                   (aw_addr_reg == trace_pkg::status_off) ||
                   (aw_addr_reg == trace_pkg::count_off) ||
                   (aw_addr_reg == trace_pkg::fifo_high_off) ||
                   (aw_addr_reg == trace_pkg::fifo_low_off);
   wire s_axi_wdata_arm_rise = w_data_reg[trace_pkg::ctl_arm_pos] &&
                               w_data_reg[trace_pkg::ctl_enable_pos];
   wire arm_write = wr_control && s_axi_wdata_arm_rise;

   // axi read path
   wire rd_take = s_axi_arvalid && !s_axi_rvalid;
   wire rd_low = rd_take && s_axi_araddr == trace_pkg::fifo_low_off;

   // trigger evaluation
   trace_pkg::trig_out_s hit;
   trace_trigger_eval u_eval (
      .mode(mode),
      .a_seen(a_seen_reg),
      .comp_a(comp_a_reg),
      .comp_b(comp_b_reg),
      .bus(cpu),
      .result(hit)
   );

   wire trig_now = armed && hit.trigger &&
                   (!opcode_qualify_select || cpu.opcode_fetch);
   wire cof_any = cpu.cof_dest || cpu.cof_branch;
   // destination stores current address, branch stores previous minus two
   wire [15:0] cof_addr = cpu.cof_dest ? cpu.addr : prev_addr_reg - 16'h0002;
   wire [15:0] event_word = {8'h00, cpu.data};
   wire full;
   wire [15:0] oldest;

   // end run: capture until trigger, the trigger cof itself included
   wire end_store = armed && !begin_run && !event_mode && cof_any;
   // begin run: nothing before trigger, then until eight words
   wire begin_store = armed && begin_run && (triggered_reg || trig_now) && !full &&
                      (event_mode ? hit.hit_b : cof_any);
   wire profile_store = !armed && module_enable_bit && rd_low;
   wire push = end_store || begin_store || profile_store;
   wire [15:0] push_word = profile_store ? cpu.addr : (event_mode ? event_word : cof_addr);
   // pop only when not armed; armed reads leave the fifo alone
   wire pop = rd_low && !armed;
   wire end_disarm = armed && !begin_run && trig_now;
   wire begin_disarm = armed && begin_run && full;
   wire end_run_reset = sys_reset && module_enable_bit && !begin_run;

   trace_capture_fifo #(
      .depth(trace_pkg::fifo_depth),
      .width(16)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .push(push),
      .push_data(push_word),
      .pop(pop),
      .clear(arm_write),
      .oldest(oldest),
      .full(full)
   );

   // control and trigger registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         control_reg <= trace_pkg::control_reset;
         trigger_reg <= trace_pkg::trigger_reset;
      end else begin
         if (end_run_reset) begin
            control_reg[trace_pkg::ctl_arm_pos] <= 1'b0;
            control_reg[trace_pkg::ctl_brk_pos] <= 1'b0;
         end else if (wr_control) begin
            control_reg <= w_data_reg[7:0];
         end else if (end_disarm || begin_disarm) begin
            control_reg[trace_pkg::ctl_arm_pos] <= 1'b0;
         end
         if (wr_trigger) trigger_reg <= w_data_reg[7:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         comp_a_reg <= '0;
         comp_b_reg <= '0;
      end else begin
         if (wr_comp_a) comp_a_reg <= w_data_reg[15:0];
         if (wr_comp_b) comp_b_reg <= w_data_reg[15:0];
      end
   end

   // armed flag and match flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         armed_status_flag <= 1'b0;
         comp_a_match_flag <= 1'b0;
         comp_b_match_flag <= 1'b0;
         comp_c_match_flag <= 1'b0;
         a_seen_reg <= 1'b0;
         triggered_reg <= 1'b0;
      end else if (arm_write) begin
         armed_status_flag <= 1'b1;
         comp_a_match_flag <= 1'b0;
         comp_b_match_flag <= 1'b0;
         comp_c_match_flag <= 1'b0;
         a_seen_reg <= 1'b0;
         triggered_reg <= 1'b0;
      end else begin
         // enable low, arm cleared, end run trigger or begin run full all drop the flag
         if (!armed || end_run_reset || end_disarm || begin_disarm)
            armed_status_flag <= 1'b0;
         if (armed && hit.hit_a) comp_a_match_flag <= 1'b1;
         if (armed && hit.hit_b) comp_b_match_flag <= 1'b1;
         if (armed && hit.hit_a) a_seen_reg <= 1'b1;
         if (trig_now) triggered_reg <= 1'b1;
      end
   end

   // valid word count saturates at fifo depth
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         valid_word_count <= '0;
      end else if (arm_write) begin
         valid_word_count <= '0;
      end else if (push && !profile_store &&
                   valid_word_count != 4'(trace_pkg::fifo_depth)) begin
         valid_word_count <= valid_word_count + 4'h1;
      end
   end

   // break request: end run at trigger, begin run at fifo full
   wire brk_end = armed && !begin_run && (tag_bit ? hit.brk_source : hit.trigger) &&
                  (!opcode_qualify_select || tag_bit || cpu.opcode_fetch);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         brk_reg <= 1'b0;
         prev_addr_reg <= '0;
      end else begin
         brk_reg <= break_request_enable && (brk_end || begin_disarm);
         prev_addr_reg <= cpu.addr;
      end
   end
   assign break_request = brk_reg;
   assign break_is_tag = tag_bit;

   // axi write channel handshake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= trace_pkg::okay;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? trace_pkg::okay : trace_pkg::slverr;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_held_reg && !s_axi_bvalid;

   // read mux; high and low registers show the two bytes of the oldest entry, high zero in event modes
   wire [15:0] fifo_view = event_mode ? {8'h00, oldest[7:0]} : oldest;
   wire [31:0] status_word = {24'h0, armed_status_flag, comp_a_match_flag,
                              comp_b_match_flag, comp_c_match_flag, 4'h0};
   wire rd_known = s_axi_araddr == trace_pkg::control_off ||
                   s_axi_araddr == trace_pkg::trigger_off ||
                   s_axi_araddr == trace_pkg::status_off ||
                   s_axi_araddr == trace_pkg::count_off ||
                   s_axi_araddr == trace_pkg::fifo_high_off ||
                   s_axi_araddr == trace_pkg::fifo_low_off ||
                   s_axi_araddr == trace_pkg::match_a_off ||
                   s_axi_araddr == trace_pkg::match_b_off;
   wire [31:0] rd_word =
      (s_axi_araddr == trace_pkg::control_off) ? {24'h0, control_reg} :
      (s_axi_araddr == trace_pkg::trigger_off) ? {24'h0, trigger_reg} :
      (s_axi_araddr == trace_pkg::status_off) ? status_word :
      (s_axi_araddr == trace_pkg::count_off) ? {28'h0, valid_word_count} :
      (s_axi_araddr == trace_pkg::fifo_high_off) ? {24'h0, fifo_view[15:8]} :
      (s_axi_araddr == trace_pkg::fifo_low_off) ? {24'h0, fifo_view[7:0]} :
      (s_axi_araddr == trace_pkg::match_a_off) ? {16'h0, comp_a_reg} :
      (s_axi_araddr == trace_pkg::match_b_off) ? {16'h0, comp_b_reg} : 32'h0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= trace_pkg::okay;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_known ? trace_pkg::okay : trace_pkg::slverr;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;
endmodule : trace_trigger_and_capture_fifo

// file: rtl/trace_trigger_eval.sv
/*
 trace_trigger_eval: combinational trigger mode evaluation.
 assumes comparator values held stable by the register file.
*/
`timescale 1ns/1ps
module trace_trigger_eval (
   input wire logic [3:0] mode,
   input wire logic a_seen,
   input wire logic [15:0] comp_a,
   input wire logic [15:0] comp_b,
   input wire trace_pkg::cpu_bus_s bus,
   output trace_pkg::trig_out_s result
);
   wire eq_a = bus.addr == comp_a;
   wire eq_b_addr = bus.addr == comp_b;
   wire eq_b_data = bus.data == comp_b[7:0];
   wire ge_a = bus.addr >= comp_a;
   wire le_b = bus.addr <= comp_b;
   logic ha;
   logic hb;
   logic brk_a_only;

   always_comb begin
      ha = 1'b0;
      hb = 1'b0;
      brk_a_only = 1'b0;
      case (mode)
         4'(trace_pkg::mode_a_only): ha = eq_a;
         4'(trace_pkg::mode_a_or_b): begin
            ha = eq_a;
            hb = eq_b_addr;
         end
         4'(trace_pkg::mode_a_then_b): begin
            ha = eq_a && !a_seen;
            hb = a_seen && eq_b_addr;
         end
         4'(trace_pkg::mode_event_b): hb = eq_b_addr;
         4'(trace_pkg::mode_a_then_event_b): begin
            ha = eq_a && !a_seen;
            hb = a_seen && eq_b_addr;
         end
         4'(trace_pkg::mode_a_and_b): begin
            ha = eq_a && eq_b_data;
            hb = ha;
            brk_a_only = eq_a;
         end
         4'(trace_pkg::mode_a_and_not_b): begin
            ha = eq_a && !eq_b_data;
            hb = ha;
            brk_a_only = eq_a;
         end
         4'(trace_pkg::mode_inside): begin
            ha = ge_a && le_b;
            hb = ha;
         end
         4'(trace_pkg::mode_outside): begin
            ha = !ge_a;
            hb = !le_b;
         end
         default: ;
      endcase
   end

   wire full_mode = (mode == 4'(trace_pkg::mode_a_and_b)) ||
                    (mode == 4'(trace_pkg::mode_a_and_not_b));
   wire is_then = (mode == 4'(trace_pkg::mode_a_then_b)) ||
                  (mode == 4'(trace_pkg::mode_a_then_event_b));

   assign result.hit_a = ha;
   assign result.hit_b = hb;
   assign result.trigger = is_then ? hb : (ha || hb);
   assign result.brk_source = full_mode ? brk_a_only : (is_then ? hb : (ha || hb));
endmodule : trace_trigger_eval

// file: tb/trace_cpu_model.sv
/*
 trace_cpu_model: cpu side of the trace block, one bus cycle per step call, n cycles per idle call.
 assumes its tasks are called just after a rising edge of clk.
*/
`timescale 1ns/1ps
module trace_cpu_model (
   input wire logic clk,
   output trace_pkg::cpu_bus_s cpu
);
   localparam logic [15:0] idle_addr = 16'h7777;
   initial cpu = '{idle_addr, 8'h00, 1'b0, 1'b0, 1'b1};
   // a branch marks the cycle after its source address
   task automatic step(input logic [15:0] a, input logic [7:0] d, input logic dst,
      input logic br);
      cpu <= '{a, d, dst, br, 1'b1};
      @(posedge clk);
   endtask : step
   // parked fetch address; data inverted so a stale value never matches
   task automatic idle(input int n);
      cpu <= '{idle_addr, ~cpu.data, 1'b0, 1'b0, 1'b1};
      repeat (n) @(posedge clk);
   endtask : idle
endmodule : trace_cpu_model

// file: tb/trace_trigger_and_capture_fifo_bench.sv
/*
 trace_trigger_and_capture_fifo_bench: register-level tests of arming, trigger modes, fifo.
 assumes trace_cpu_model drives the cpu bus and the checker is bound to DUT.
*/
`timescale 1ns/1ps
module trace_trigger_and_capture_fifo_bench;
   logic clk;
   logic rst = 1'b1;
   logic sys_reset = 1'b0;
   trace_pkg::cpu_bus_s cpu;
   logic break_request, break_is_tag, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rresp_got;
   logic [31:0] s_axi_rdata;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [15:0] end_words [3] = '{16'h2000, 16'h2ffe, 16'h1234};
   int miscompares = 0, checks_done = 0, brk_seen = 0, cycles = 0;
   trace_trigger_and_capture_fifo DUT (.clk, .rst, .sys_reset, .cpu, .break_request,
      .break_is_tag, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   trace_cpu_model cpu_m (.clk, .cpu);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (break_request === 1'b1) brk_seen++;
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      rresp_got = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] d;
      rd(a, d);
      chk({24'h0, d[7:0]}, {24'h0, e});
   endtask : rc
   task automatic run_mode(input logic [3:0] m, input logic [15:0] cb, input logic [15:0] a,
      input logic [7:0] d, input logic [7:0] e);
      wr(trace_pkg::match_b_off, {16'h0, cb});
      wr(trace_pkg::trigger_off, {28'h0, m});
      wr(trace_pkg::control_off, 32'hc0);
      cpu_m.step(a, d, 1'b0, 1'b0);
      cpu_m.idle(2);
      rc(trace_pkg::status_off, e);
   endtask : run_mode
   initial begin
      logic [31:0] d;
      int i;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rc(trace_pkg::control_off, trace_pkg::control_reset);
      rc(trace_pkg::trigger_off, trace_pkg::trigger_reset);
      rd(8'h20, d);
      chk({30'h0, rresp_got}, {30'h0, trace_pkg::slverr});
      wr(trace_pkg::match_a_off, 32'h1234);
      wr(trace_pkg::match_b_off, 32'h5678);
      wr(trace_pkg::control_off, 32'h40);
      rc(trace_pkg::status_off, 8'h00);
      wr(trace_pkg::control_off, 32'hc0);
      rc(trace_pkg::status_off, 8'h80);
      wr(trace_pkg::control_off, 32'h80);
      rc(trace_pkg::status_off, 8'h00);
      // end run: destination, taken branch, trigger on a destination
      wr(trace_pkg::control_off, 32'hd0);
      cpu_m.step(16'h2000, 8'h00, 1'b1, 1'b0);
      cpu_m.step(16'h3000, 8'h00, 1'b0, 1'b0);
      cpu_m.step(16'h3005, 8'h00, 1'b0, 1'b1);
      cpu_m.step(16'h1234, 8'h00, 1'b1, 1'b0);
      cpu_m.idle(3);
      chk(brk_seen, 1);
      rc(trace_pkg::status_off, 8'h40);
      rc(trace_pkg::count_off, 8'h03);
      for (i = 0; i < 3; i++) begin
         rc(trace_pkg::fifo_high_off, end_words[i][15:8]);
         rc(trace_pkg::fifo_low_off, end_words[i][7:0]);
      end
      rc(trace_pkg::count_off, 8'h03);
      // reads while armed, then a system reset ends the end run
      wr(trace_pkg::control_off, 32'hc0);
      cpu_m.step(16'h40a5, 8'h00, 1'b1, 1'b0);
      cpu_m.step(16'h4111, 8'h00, 1'b1, 1'b0);
      cpu_m.idle(2);
      rc(trace_pkg::fifo_low_off, 8'ha5);
      rc(trace_pkg::fifo_low_off, 8'ha5);
      sys_reset <= 1'b1;
      @(posedge clk);
      sys_reset <= 1'b0;
      @(posedge clk);
      rc(trace_pkg::status_off, 8'h00);
      rc(trace_pkg::control_off, 8'h80);
      // begin run fills the fifo after the trigger
      wr(trace_pkg::trigger_off, 32'h40);
      wr(trace_pkg::control_off, 32'hd0);
      cpu_m.step(16'h5000, 8'h00, 1'b1, 1'b0);
      cpu_m.step(16'h1234, 8'h00, 1'b0, 1'b0);
      cpu_m.idle(1);
      for (i = 0; i < 8; i++) cpu_m.step(16'h6000 + 16'(i * 16), 8'h00, 1'b1, 1'b0);
      cpu_m.idle(3);
      chk(brk_seen, 2);
      rc(trace_pkg::status_off, 8'h40);
      rc(trace_pkg::count_off, 8'h08);
      for (i = 0; i < 8; i++) begin
         rc(trace_pkg::fifo_high_off, 8'h60);
         rc(trace_pkg::fifo_low_off, 8'(i * 16));
      end
      rc(trace_pkg::fifo_high_off, 8'h77);
      rc(trace_pkg::count_off, 8'h08);
      run_mode(trace_pkg::mode_a_only, 16'h5678, 16'h1234, 8'h00, 8'h40);
      run_mode(trace_pkg::mode_a_or_b, 16'h5678, 16'h5678, 8'h00, 8'h20);
      run_mode(trace_pkg::mode_a_and_b, 16'h0056, 16'h1234, 8'h56, 8'h60);
      run_mode(trace_pkg::mode_a_and_not_b, 16'h0056, 16'h1234, 8'h57, 8'h60);
      run_mode(trace_pkg::mode_event_b, 16'h5678, 16'h5678, 8'h3c, 8'ha0);
      rc(trace_pkg::fifo_high_off, 8'h00);
      rc(trace_pkg::fifo_low_off, 8'h3c);
      run_mode(trace_pkg::mode_a_then_event_b, 16'h5678, 16'h5678, 8'h00, 8'h80);
      run_mode(trace_pkg::mode_a_then_b, 16'h5678, 16'h5678, 8'h00, 8'h80);
      run_mode(trace_pkg::mode_inside, 16'h5678, 16'h3000, 8'h00, 8'h60);
      run_mode(trace_pkg::mode_outside, 16'h5678, 16'h6000, 8'h00, 8'h20);
      // tag break in a full mode follows comparator a alone
      wr(trace_pkg::trigger_off, 32'h82);
      wr(trace_pkg::control_off, 32'hf0);
      chk({31'h0, break_is_tag}, 32'h1);
      cpu_m.step(16'h1234, 8'h00, 1'b0, 1'b0);
      cpu_m.idle(2);
      chk(brk_seen, 3);
      rc(trace_pkg::status_off, 8'h80);
      print_verdict();
   end
endmodule : trace_trigger_and_capture_fifo_bench

// file: tb/trace_trigger_and_capture_fifo_checker.sv
/*
 trace_trigger_and_capture_fifo_checker: assertions on break output and register slave.
 assumes it is bound to the trace block and sees only its ports.
*/
`timescale 1ns/1ps
module trace_trigger_and_capture_fifo_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic break_request,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_break_pulse; break_request |=> !break_request; endproperty
   a_break_pulse: assert property (p_break_pulse) else $error("break too long");
   property p_b_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid; endproperty
   a_b_answer: assert property (p_b_answer) else $error("write response late");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_w_block: assert property (p_w_block) else $error("write taken during response");
   property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_answer: assert property (p_r_answer) else $error("read data late");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_r_cause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
   a_r_cause: assert property (p_r_cause) else $error("read data without request");
   property p_bad_addr; s_axi_rvalid && s_axi_rresp == trace_pkg::slverr |-> s_axi_rdata == 0;
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("unmapped read data not zero");
   c_break: cover property (break_request);
   c_bad_addr: cover property (s_axi_rvalid && s_axi_rresp == trace_pkg::slverr);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : trace_trigger_and_capture_fifo_checker
bind trace_trigger_and_capture_fifo trace_trigger_and_capture_fifo_checker chk_i (.clk, .rst,
   .break_request, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
